// ### core/gpcm_top.sv
// Configuration and function multiplexing for ten general purpose pins.
// Assumes one 50 MHz clock, synchronous reset and an APB master; pins
// arrive asynchronously, alternate-function units share the clock.
`timescale 1ns/1ps

// How it works
// - Bit 0 high makes pin input in GPIO mode.
// - Bit 1 inverts pin value both ways.
// - Bank-1 bit 2 joins combined group one.
// - Bank-5/6 bit 5 joins combined group two.
// - Bit 7 selects open-drain over push-pull.
// - Indicator pin bit 3 routes LED output.
// - Bank-1 pin 4 bit 3: infrared receive.
// - Bank-1 pin 5 bit 3: infrared transmit.
// - Bank-1 pin 6 bit 3: floppy motor.
// - Bank-1 pin 7 bit 3: floppy select.
// - Bank-5 pin 0: PCI clock, IRQ14, GPIO.
// - Bank-5 pin 2: density, GPIO, IRQ8, SMI.
// - Bank-5 pin 3: ROM select, IRQ11, GPIO, edge.
// - Bank-5 pin 4: ROM enable, IRQ12, GPIO, edge.
// - Bank-6 pin 0: ROM data, IRQ1, GPIO, SMI.
// - Reserved configuration bits change nothing.
// - Reset loads each configuration default value.
// - Group mapping field picks IRQ, zero disables.
module gpcm_top
    import gpcm_pkg::*;
#(
    parameter int NPINS = gpcm_pkg::GPCM_NPINS
) (
    input wire logic ref_clk, // System clock, 50 MHz.
    input wire logic reset, // Synchronous reset, active high.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [gpcm_pkg::GPCM_AW-1:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    input wire logic [3:0] pstrb, // APB byte lane strobes.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error, unmapped address.
    input wire logic [NPINS-1:0] pin_in, // Pin levels from pads.
    output logic [NPINS-1:0] pin_out, // Pin drive levels.
    output logic [NPINS-1:0] pin_oe, // Pin drive enables.
    input wire logic led_drive, // LED function level.
    input wire logic infrared_transmit_2, // Second IR transmit.
    input wire logic floppy_motor_enable_1, // Drive 1 motor level.
    input wire logic floppy_drive_select_1, // Drive 1 select level.
    input wire logic drive_density_select_1, // Density select level.
    input wire logic bios_rom_chip_select, // ROM chip select level.
    input wire logic bios_rom_output_enable, // ROM output enable level.
    input wire logic system_mgmt_interrupt_out, // SMI level.
    input wire logic rom_data_bit0_out, // ROM data bit 0 to drive.
    input wire logic rom_data_bit0_oe, // ROM data bit 0 drive enable.
    output logic infrared_receive_2, // Second IR receive.
    output logic pci_clock_in, // PCI clock seen on the pin.
    output logic irq1_req, // IRQ1 request from pin.
    output logic irq8_req, // IRQ8 request from pin.
    output logic irq11_req, // IRQ11 request from pin.
    output logic irq12_req, // IRQ12 request from pin.
    output logic irq14_req, // IRQ14 request from pin.
    output logic rom_data_bit0_in, // ROM data bit 0 from pin.
    output logic [15:0] combined_irq, // Combined group IRQ lines.
    output logic irq // Block interrupt, level.
);

    // ****************************************************************
    // State
    // ****************************************************************
    logic [7:0] cfg_reg [0:NPINS-1];
    logic [7:0] grp1_map_reg;
    logic [7:0] grp2_map_reg;
    logic [15:0] data_reg;
    logic [3:0] status_reg;
    logic [3:0] enable_reg;
    logic [NPINS-1:0] sync1_reg;
    logic [NPINS-1:0] sync2_reg;
    logic [1:0] edge_prev_reg;
    logic grp1_prev_reg;
    logic grp2_prev_reg;

    logic [NPINS-1:0] adj_in;
    logic [NPINS-1:0] is_gpio;
    logic [NPINS-1:0] alt_drv;
    logic [NPINS-1:0] alt_val;
    logic [NPINS-1:0] pin_out_next;
    logic [NPINS-1:0] pin_oe_next;
    logic [1:0] fsel [0:NPINS-1];
    logic grp1_act;
    logic grp2_act;
    logic [3:0] events;
    logic [7:0] idx;
    logic addr_ok;
    logic hit;
    logic [31:0] rdata_next;
    logic wr_en;
    logic [15:0] wmask;

    // ****************************************************************
    // Pin input synchroniser
    // ****************************************************************
    // Two flops isolate the asynchronous pads from the logic.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
        end
    end

    // ****************************************************************
    // Function multiplexing
    // ****************************************************************
    // Picks plain GPIO or the alternate function for each pin.
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            fsel[i] = cfg_reg[i][GPCM_BIT_FSEL_HI:GPCM_BIT_FSEL_LO];
            adj_in[i] = sync2_reg[i] ^ cfg_reg[i][GPCM_BIT_POL];
            is_gpio[i] = 1'b1;
            alt_drv[i] = 1'b0;
            alt_val[i] = 1'b0;
        end
        // Bank-1 and indicator pins use bit 3 alone.
        if (cfg_reg[0][GPCM_BIT_FSEL_LO]) begin
            is_gpio[0] = 1'b0;
            alt_drv[0] = 1'b1;
            alt_val[0] = led_drive;
        end
        is_gpio[1] = !cfg_reg[1][GPCM_BIT_FSEL_LO];
        if (cfg_reg[2][GPCM_BIT_FSEL_LO]) begin
            is_gpio[2] = 1'b0;
            alt_drv[2] = 1'b1;
            alt_val[2] = infrared_transmit_2;
        end
        if (cfg_reg[3][GPCM_BIT_FSEL_LO]) begin
            is_gpio[3] = 1'b0;
            alt_drv[3] = 1'b1;
            alt_val[3] = floppy_motor_enable_1;
        end
        if (cfg_reg[4][GPCM_BIT_FSEL_LO]) begin
            is_gpio[4] = 1'b0;
            alt_drv[4] = 1'b1;
            alt_val[4] = floppy_drive_select_1;
        end
        // Bank-5 pin 0: only 10 is GPIO; 11 leaves the pin idle.
        is_gpio[5] = (fsel[5] == GPCM_F10);
        // Bank-5 pin 2.
        is_gpio[6] = (fsel[6] == GPCM_F01);
        if (fsel[6] == GPCM_F00) begin
            alt_drv[6] = 1'b1;
            alt_val[6] = drive_density_select_1;
        end else if (fsel[6] == GPCM_F11) begin
            alt_drv[6] = 1'b1;
            alt_val[6] = system_mgmt_interrupt_out;
        end
        // Bank-5 pins 3 and 4.
        is_gpio[7] = (fsel[7] == GPCM_F10);
        if (fsel[7] == GPCM_F00) begin
            alt_drv[7] = 1'b1;
            alt_val[7] = bios_rom_chip_select;
        end
        is_gpio[8] = (fsel[8] == GPCM_F10);
        if (fsel[8] == GPCM_F00) begin
            alt_drv[8] = 1'b1;
            alt_val[8] = bios_rom_output_enable;
        end
        // Bank-6 pin 0; the ROM data path turns around on its enable.
        is_gpio[9] = (fsel[9] == GPCM_F10);
        if (fsel[9] == GPCM_F00) begin
            alt_drv[9] = rom_data_bit0_oe;
            alt_val[9] = rom_data_bit0_out;
        end else if (fsel[9] == GPCM_F11) begin
            alt_drv[9] = 1'b1;
            alt_val[9] = system_mgmt_interrupt_out;
        end
    end

    // ****************************************************************
    // Pad drive
    // ****************************************************************
    // Open-drain pins only pull low; push-pull pins drive both levels.
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            logic drv;
            logic lvl;
            drv = alt_drv[i] | (is_gpio[i] & !cfg_reg[i][GPCM_BIT_DIR]);
            lvl = (alt_drv[i] ? alt_val[i] : data_reg[i])
                ^ cfg_reg[i][GPCM_BIT_POL];
            if (cfg_reg[i][GPCM_BIT_ODRAIN]) begin
                pin_oe_next[i] = drv & !lvl;
                pin_out_next[i] = 1'b0;
            end else begin
                pin_oe_next[i] = drv;
                pin_out_next[i] = lvl;
            end
        end
    end

    // Registers the pad drive.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin_out <= '0;
            pin_oe <= '0;
        end else begin
            pin_out <= pin_out_next;
            pin_oe <= pin_oe_next;
        end
    end

    // ****************************************************************
    // Inputs routed to alternate units
    // ****************************************************************
    // Each routed input is low unless its function is selected.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            infrared_receive_2 <= 1'b0;
            pci_clock_in <= 1'b0;
            irq14_req <= 1'b0;
            irq8_req <= 1'b0;
            irq11_req <= 1'b0;
            irq12_req <= 1'b0;
            irq1_req <= 1'b0;
            rom_data_bit0_in <= 1'b0;
        end else begin
            infrared_receive_2 <= !is_gpio[1] & adj_in[1];
            pci_clock_in <= (fsel[5] == GPCM_F00) & adj_in[5];
            irq14_req <= (fsel[5] == GPCM_F01) & adj_in[5];
            irq8_req <= (fsel[6] == GPCM_F10) & adj_in[6];
            irq11_req <= (fsel[7] == GPCM_F01) & adj_in[7];
            irq12_req <= (fsel[8] == GPCM_F01) & adj_in[8];
            irq1_req <= (fsel[9] == GPCM_F01) & adj_in[9];
            rom_data_bit0_in <= (fsel[9] == GPCM_F00) & adj_in[9];
        end
    end

    // ****************************************************************
    // Combined groups and events
    // ****************************************************************
    // A group is active while any member GPIO input reads high.
    always_comb begin
        grp1_act = 1'b0;
        grp2_act = 1'b0;
        for (int i = 0; i < NPINS; i++) begin
            if (i <= GPCM_BANK1_LAST) begin
                grp1_act = grp1_act | (cfg_reg[i][GPCM_BIT_GRP1]
                    & is_gpio[i] & adj_in[i]);
            end else begin
                grp2_act = grp2_act | (cfg_reg[i][GPCM_BIT_GRP2]
                    & is_gpio[i] & adj_in[i]);
            end
        end
        events = '0;
        events[GPCM_ST_EDGE3] = (fsel[7] == GPCM_F11)
            & (adj_in[7] ^ edge_prev_reg[0]);
        events[GPCM_ST_EDGE4] = (fsel[8] == GPCM_F11)
            & (adj_in[8] ^ edge_prev_reg[1]);
        events[GPCM_ST_GRP1] = grp1_act & !grp1_prev_reg;
        events[GPCM_ST_GRP2] = grp2_act & !grp2_prev_reg;
    end

    // Keeps the previous levels for edge detection.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            edge_prev_reg <= '0;
            grp1_prev_reg <= 1'b0;
            grp2_prev_reg <= 1'b0;
        end else begin
            edge_prev_reg <= {adj_in[8], adj_in[7]};
            grp1_prev_reg <= grp1_act;
            grp2_prev_reg <= grp2_act;
        end
    end

    // Drives the IRQ line chosen by each group's mapping field.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            combined_irq <= '0;
        end else begin
            combined_irq <= '0;
            if (grp1_map_reg[GPCM_MAP_HI:GPCM_MAP_LO] != GPCM_MAP_OFF) begin
                combined_irq[grp1_map_reg[GPCM_MAP_HI:GPCM_MAP_LO]]
                    <= grp1_act;
            end
            if (grp2_map_reg[GPCM_MAP_HI:GPCM_MAP_LO] != GPCM_MAP_OFF) begin
                if (grp2_act) begin
                    combined_irq[grp2_map_reg[GPCM_MAP_HI:GPCM_MAP_LO]]
                        <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // APB decode
    // ****************************************************************
    // Decodes the word index and builds read data in the setup cycle.
    always_comb begin
        idx = paddr[9:2];
        addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
        hit = 1'b0;
        rdata_next = '0;
        for (int i = 0; i < NPINS; i++) begin
            if (idx == GPCM_CFG_IDX[i]) begin
                hit = 1'b1;
                rdata_next[7:0] = cfg_reg[i];
            end
        end
        case (idx)
            GPCM_IDX_GRP1_MAP: begin
                hit = 1'b1;
                rdata_next[7:0] = grp1_map_reg;
            end
            GPCM_IDX_GRP2_MAP: begin
                hit = 1'b1;
                rdata_next[7:0] = grp2_map_reg;
            end
            GPCM_IDX_DATA: begin
                hit = 1'b1;
                rdata_next[NPINS-1:0] = adj_in;
            end
            GPCM_IDX_STATUS: begin
                hit = 1'b1;
                rdata_next[3:0] = status_reg;
            end
            GPCM_IDX_ENABLE: begin
                hit = 1'b1;
                rdata_next[3:0] = enable_reg;
            end
            GPCM_IDX_CLEAR: begin
                hit = 1'b1;
            end
            default: begin
            end
        endcase
        hit = hit & addr_ok;
        if (!hit) begin
            rdata_next = '0;
        end
        wr_en = psel & penable & pready & pwrite & !pslverr;
        wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    end

    // Answers one cycle after setup, so every access has no wait state.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= psel & !penable;
            pslverr <= psel & !penable & !hit;
            prdata <= (psel & !penable & !pwrite) ? rdata_next : '0;
        end
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    // Configuration bytes; reserved bits store but steer nothing.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            for (int i = 0; i < NPINS; i++) begin
                cfg_reg[i] <= GPCM_CFG_RST[i];
            end
        end else begin
            for (int i = 0; i < NPINS; i++) begin
                if (wr_en && pstrb[0] && idx == GPCM_CFG_IDX[i]) begin
                    cfg_reg[i] <= pwdata[7:0];
                end
            end
        end
    end

    // Group mapping and GPIO output data.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            grp1_map_reg <= GPCM_MAP_RST;
            grp2_map_reg <= GPCM_MAP_RST;
            data_reg <= GPCM_DATA_RST;
        end else if (wr_en) begin
            if (idx == GPCM_IDX_GRP1_MAP && pstrb[0]) begin
                grp1_map_reg <= pwdata[7:0];
            end
            if (idx == GPCM_IDX_GRP2_MAP && pstrb[0]) begin
                grp2_map_reg <= pwdata[7:0];
            end
            if (idx == GPCM_IDX_DATA) begin
                data_reg <= (data_reg & ~wmask) | (pwdata[15:0] & wmask);
            end
        end
    end

    // ****************************************************************
    // Interrupt status
    // ****************************************************************
    // Sticky status; a new event wins over a clear in the same cycle.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            status_reg <= GPCM_IRQ_RST;
            enable_reg <= GPCM_IRQ_RST;
        end else begin
            if (wr_en && pstrb[0] && idx == GPCM_IDX_CLEAR) begin
                status_reg <= (status_reg & ~pwdata[3:0]) | events;
            end else begin
                status_reg <= status_reg | events;
            end
            if (wr_en && pstrb[0] && idx == GPCM_IDX_ENABLE) begin
                enable_reg <= pwdata[3:0];
            end
        end
    end

    // Level interrupt from enabled status.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_reg & enable_reg);
        end
    end

endmodule

// ### core/gpcm_pkg.sv
// Constants shared by the multiplexed GPIO pin configuration block.
// Assumes a 32-bit APB register bus and ten multiplexed pins.
package gpcm_pkg;

    // ****************************************************************
    // Pin numbering and register indices
    // ****************************************************************
    localparam int GPCM_NPINS = 10;
    localparam int GPCM_AW = 12;
    // Pin slots: 0 indicator, 1..4 bank-1 pins 4..7, 5..8 bank-5 pins
    // 0,2,3,4, 9 bank-6 pin 0.
    localparam logic [7:0] GPCM_CFG_IDX [0:9] = '{
        8'hE3, 8'hE4, 8'hE5, 8'hE6, 8'hE7,
        8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hD0};
    localparam logic [7:0] GPCM_CFG_RST [0:9] = '{
        8'h01, 8'h01, 8'h00, 8'h01, 8'h01,
        8'h01, 8'h09, 8'h01, 8'h01, 8'h01};
    localparam logic [7:0] GPCM_IDX_GRP2_MAP = 8'hEF;
    localparam logic [7:0] GPCM_IDX_GRP1_MAP = 8'hF0;
    localparam logic [7:0] GPCM_IDX_DATA = 8'hF8;
    localparam logic [7:0] GPCM_IDX_STATUS = 8'hF9;
    localparam logic [7:0] GPCM_IDX_ENABLE = 8'hFA;
    localparam logic [7:0] GPCM_IDX_CLEAR = 8'hFB;
    localparam logic [7:0] GPCM_MAP_RST = 8'h00;
    localparam logic [15:0] GPCM_DATA_RST = 16'h0000;
    localparam logic [3:0] GPCM_IRQ_RST = 4'h0;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int GPCM_BIT_DIR = 0;
    localparam int GPCM_BIT_POL = 1;
    localparam int GPCM_BIT_GRP1 = 2;
    localparam int GPCM_BIT_FSEL_LO = 3;
    localparam int GPCM_BIT_FSEL_HI = 4;
    localparam int GPCM_BIT_GRP2 = 5;
    localparam int GPCM_BIT_ODRAIN = 7;
    localparam int GPCM_MAP_LO = 4;
    localparam int GPCM_MAP_HI = 7;
    localparam int GPCM_BANK1_LAST = 4;
    // Status bit positions.
    localparam int GPCM_ST_EDGE3 = 0;
    localparam int GPCM_ST_EDGE4 = 1;
    localparam int GPCM_ST_GRP1 = 2;
    localparam int GPCM_ST_GRP2 = 3;

    // ****************************************************************
    // Two-bit function select codes
    // ****************************************************************
    localparam logic [1:0] GPCM_F00 = 2'h0;
    localparam logic [1:0] GPCM_F01 = 2'h1;
    localparam logic [1:0] GPCM_F10 = 2'h2;
    localparam logic [1:0] GPCM_F11 = 2'h3;
    localparam logic [3:0] GPCM_MAP_OFF = 4'h0;

endpackage

// ### dv/gpcm_pad_model.sv
// Board pads beside the pin block: one resolved level for each pad.
// Assumes a pull-up on every pad and a bench that may drive it too.
`timescale 1ns/1ps
module gpcm_pad_model #(
    parameter int NPINS = 10
) (
    input wire logic [NPINS-1:0] pin_out, // Device drive level.
    input wire logic [NPINS-1:0] pin_oe, // Device drive enable.
    input wire logic [NPINS-1:0] ext_level, // Board drive level.
    input wire logic [NPINS-1:0] ext_en, // Board drive enable.
    output logic [NPINS-1:0] pad // Resolved pad level.
);
    // The device drive wins; a pad nobody drives floats to its pull-up.
    assign pad = (pin_oe & pin_out) | (~pin_oe & (ext_level | ~ext_en));
endmodule

// ### dv/gpcm_monitor.sv
// Port checker for the pin configuration block.
// Assumes the ports of gpcm_top; bound to it at the foot of this file.
`timescale 1ns/1ps
module gpcm_monitor #(
    parameter int NPINS = 10
) (
    input wire logic ref_clk, // Clock.
    input wire logic reset, // Reset, active high.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction.
    input wire logic [gpcm_pkg::GPCM_AW-1:0] paddr, // APB address.
    input wire logic [31:0] pwdata, // APB write data.
    input wire logic [3:0] pstrb, // APB strobes.
    input wire logic [31:0] prdata, // APB read data.
    input wire logic pready, // APB ready.
    input wire logic pslverr, // APB error.
    input wire logic [NPINS-1:0] pin_out, // Pin drive levels.
    input wire logic [NPINS-1:0] pin_oe, // Pad enables.
    input wire logic infrared_transmit_2, // IR transmit level.
    input wire logic [15:0] combined_irq, // Group lines.
    input wire logic irq // Block interrupt.
);
    import gpcm_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Accepted write of lane 0.
    logic wr_done;
    assign wr_done = psel && penable && pready && pwrite && !pslverr
        && pstrb[0];
    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    chk_err_with_ready: assert property (pslverr |-> pready && penable)
        else $error("error outside access cycle");
    chk_rdata_idle: assert property (!pready || pwrite |-> prdata == 32'h0)
        else $error("read data outside read access");
    chk_reset_quiet: assert property ($fell(reset) |->
        pin_oe == '0 && irq == 1'b0 && combined_irq == 16'h0000)
        else $error("outputs active after reset");
    chk_input_released: assert property (
        wr_done && paddr == 12'h398 && pwdata[0] && !pwdata[3]
        |=> ##1 !pin_oe[3]) else $error("input pin still driven");
    chk_drain_low: assert property (
        wr_done && paddr == 12'h390 && pwdata[7] |-> ##2 !pin_out[1])
        else $error("open drain pin driven high");
    chk_tx_route: assert property (
        wr_done && paddr == 12'h394 && pwdata[7:0] == 8'h08 |=> ##1
        pin_out[2] == $past(infrared_transmit_2) && pin_oe[2])
        else $error("transmit not routed to pin");
    chk_map_zero_off: assert property (!combined_irq[0])
        else $error("disabled mapping drives a line");
    cover property (pslverr);
    cover property ($rose(irq));
    cover property (combined_irq != 16'h0000);
endmodule
bind gpcm_top gpcm_monitor #(.NPINS(NPINS)) mon_u (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .pin_out(pin_out), .pin_oe(pin_oe), .combined_irq(combined_irq),
    .infrared_transmit_2(infrared_transmit_2));

// ### dv/test_gpcm_top.sv
// Self-checking bench for the pin configuration block.
// Assumes the design, checker and pad model are compiled first.
`timescale 1ns/1ps
module test_gpcm_top;
    import gpcm_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd_data;
    logic pready, pslverr, rd_err, irq;
    logic [9:0] pin_in, pin_out, pin_oe, alt = 10'h000;
    logic [9:0] ext_level = 10'h000, ext_en = 10'h3FF;
    logic [7:0] rte;
    logic [15:0] combined_irq;
    int errors = 0, samples_checked = 0, cycles = 0;
    // Output functions: index, config, slot, source bit.
    logic [23:0] otab [10] = '{24'hE30800, 24'hE50821, 24'hE60832,
        24'hE70843, 24'hCA0064, 24'hCB0075, 24'hCC0086, 24'hCA1867,
        24'hD00098, 24'hD01897};
    // Input functions: index, config, slot, routed bit.
    logic [23:0] itab [9] = '{24'hE40917, 24'hC80156, 24'hC80951,
        24'hCA1164, 24'hCB0973, 24'hCC0982, 24'hD00995, 24'hD00190,
        24'hD00B95};
    gpcm_top dut_u (
        .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .led_drive(alt[0]), .infrared_transmit_2(alt[1]),
        .floppy_motor_enable_1(alt[2]), .floppy_drive_select_1(alt[3]),
        .drive_density_select_1(alt[4]), .bios_rom_chip_select(alt[5]),
        .bios_rom_output_enable(alt[6]),
        .system_mgmt_interrupt_out(alt[7]),
        .rom_data_bit0_out(alt[8]), .rom_data_bit0_oe(alt[8]),
        .infrared_receive_2(rte[7]), .pci_clock_in(rte[6]),
        .irq1_req(rte[5]), .irq8_req(rte[4]), .irq11_req(rte[3]),
        .irq12_req(rte[2]), .irq14_req(rte[1]),
        .rom_data_bit0_in(rte[0]), .combined_irq(combined_irq), .irq(irq));
    gpcm_pad_model pads_u (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_level(ext_level), .ext_en(ext_en), .pad(pin_in));
    // Free-running 50 MHz clock.
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    // Cuts a hung run short.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            errors++;
            wrap_up();
        end
    end
    // ****
    // Shared tasks.
    // ****
    task automatic chk(input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h, expected %h", $time,
                seen, exp);
        end
    endtask
    // One APB transfer; holds the request until ready is sampled high.
    task automatic apb(input logic [11:0] a, input logic [31:0] d,
        input logic w);
        @(posedge ref_clk);
        psel <= 1'b1;
        paddr <= a;
        pwdata <= d;
        pwrite <= w;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] v);
        apb({2'b00, idx, 2'b00}, v, 1'b1);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        apb({2'b00, idx, 2'b00}, 32'h0, 1'b0);
        chk(rd_data, exp);
    endtask
    // Waits out the pad-to-logic delay.
    task automatic settle();
        repeat (8) @(posedge ref_clk);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ****
    // Test sequence.
    // ****
    initial begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            rd(GPCM_CFG_IDX[i], {24'h0, GPCM_CFG_RST[i]});
        end
        apb(12'h391, 32'h0, 1'b0);
        chk(rd_err, 1'b1);
        chk(rd_data, 32'h0);
        $display("reset values and refusal done");
        wr(8'hE4, 32'h71);
        rd(8'hE4, 32'h71);
        chk(pin_oe[1], 1'b0);
        wr(8'hE4, 32'h00);
        wr(8'hF8, 32'h2);
        settle();
        chk({pin_oe[1], pin_out[1]}, 2'b11);
        wr(8'hE4, 32'h02);
        settle();
        chk({pin_oe[1], pin_out[1]}, 2'b10);
        wr(8'hE4, 32'h80);
        settle();
        chk(pin_oe[1], 1'b0);
        wr(8'hF8, 32'h0);
        settle();
        chk({pin_oe[1], pin_out[1]}, 2'b10);
        $display("plain output done");
        for (int k = 0; k < 10; k++) begin
            wr(otab[k][23:16], {24'h0, otab[k][15:8]});
            for (int v = 0; v < 2; v++) begin
                alt <= {9'h000, v[0]} << otab[k][3:0];
                settle();
                chk(pin_out[otab[k][7:4]] & pin_oe[otab[k][7:4]],
                    v[0]);
            end
        end
        alt <= 10'h000;
        $display("output functions done");
        for (int k = 0; k < 9; k++) begin
            wr(itab[k][23:16], {24'h0, itab[k][15:8]});
            for (int v = 0; v < 2; v++) begin
                ext_level <= {9'h000, v[0]} << itab[k][7:4];
                settle();
                chk(rte, {7'h00, v[0] ^ itab[k][9]}
                    << itab[k][3:0]);
            end
        end
        $display("input functions done");
        wr(8'hCB, 32'h19);
        wr(8'hFB, 32'hF);
        wr(8'hFA, 32'h1);
        ext_level <= 10'h080;
        settle();
        chk(irq, 1'b1);
        rd(8'hF9, 32'h1);
        wr(8'hFB, 32'h1);
        settle();
        chk(irq, 1'b0);
        rd(8'hF9, 32'h0);
        wr(8'hFA, 32'h0);
        ext_level <= 10'h000;
        settle();
        rd(8'hF9, 32'h1);
        chk(irq, 1'b0);
        $display("edge interrupt done");
        wr(8'hCA, 32'h29);
        wr(8'hEF, 32'h30);
        ext_level <= 10'h040;
        settle();
        chk(combined_irq, 16'h0008);
        wr(8'hCA, 32'h6D);
        settle();
        chk(combined_irq, 16'h0008);
        wr(8'hEF, 32'h00);
        settle();
        chk(combined_irq, 16'h0000);
        wr(8'hE6, 32'h05);
        wr(8'hF0, 32'hF0);
        ext_level <= 10'h008;
        settle();
        chk(combined_irq, 16'h8000);
        wr(8'hE6, 32'h01);
        settle();
        chk(combined_irq, 16'h0000);
        $display("combined groups done");
        wrap_up();
    end
endmodule
